// ### rtl/uflc_pkg.sv
package uflc_pkg;

	// ----------------------------------------------------------------
	// register map: word index, byte address is four times the index
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_BAUD = 6'h00;
	localparam logic [5:0] IDX_FRAME = 6'h02;
	localparam logic [5:0] IDX_CTRL = 6'h03;
	localparam logic [5:0] IDX_STAT = 6'h04;
	localparam logic [5:0] IDX_DATA = 6'h07;

	// ----------------------------------------------------------------
	// frame_control fields
	// ----------------------------------------------------------------
	localparam int FC_LOOP = 7;
	localparam int FC_HALT = 6;
	localparam int FC_SRC = 5;
	localparam int FC_LEN9 = 4;
	localparam int FC_WAKE = 3;
	localparam int FC_ICT = 2;
	localparam int FC_PEN = 1;
	localparam int FC_PODD = 0;
	localparam logic [7:0] FC_RESET = 8'h00;

	// ----------------------------------------------------------------
	// transfer control and status fields
	// ----------------------------------------------------------------
	localparam int CT_TXEN = 0;
	localparam int CT_RXEN = 1;
	localparam int CT_DIR = 2;
	localparam int CT_RWU = 3;
	localparam logic [3:0] CT_RESET = 4'h0;
	localparam int ST_RXFULL = 0;
	localparam int ST_OVR = 1;
	localparam int ST_PERR = 2;
	localparam int ST_FERR = 3;
	localparam int ST_IDLE = 4;
	localparam int ST_TXEMPTY = 5;
	localparam int ST_TXFULL = 6;
	localparam int ST_HALTED = 7;

	// ----------------------------------------------------------------
	// widths, counts and reset values
	// ----------------------------------------------------------------
	localparam int BAUD_W = 13;
	localparam logic [12:0] BAUD_RESET = 13'h0010;
	localparam int CHAR_W = 9;
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] LEN_8 = 4'h8;
	localparam logic [3:0] LEN_9 = 4'h9;
	localparam logic [3:0] IDLE_BITS_8 = 4'ha;
	localparam logic [3:0] IDLE_BITS_9 = 4'hb;

	typedef enum logic [1:0] {
		UFLC_IDLE = 2'b00,
		UFLC_START = 2'b01,
		UFLC_DATA = 2'b11,
		UFLC_STOP = 2'b10
	} uflc_state_t;

endpackage

// ### rtl/uflc_fifo.sv
`timescale 1ns/1ps
module uflc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wr_r;
	logic [AW:0] wr_nxt;
	logic [AW:0] rd_r;
	logic [AW:0] rd_nxt;
	logic push;
	logic pop;

	// ----------------------------------------------------------------
	// full when pointers differ only in the wrap bit
	// ----------------------------------------------------------------
	always_comb begin
		in_ready = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
		out_valid = (wr_r != rd_r);
		out_data = mem_r[rd_r[AW-1:0]];
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_nxt = push ? wr_r + 1'b1 : wr_r;
		rd_nxt = pop ? rd_r + 1'b1 : rd_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
		end
	end

	// storage has no reset: nothing reads a slot before it is written
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_r[AW-1:0]] <= in_data;
		end
	end
endmodule

// ### rtl/uflc_core.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - loop select clear: full duplex, tx pin driven while transmitter enabled or busy, rx pin sampled
// - loop select set: receiver fed from transmitter output or tx pin, rx pin ignored
// - receiver source bit has no effect while loop select is clear
// - loop set, source 0: internal loopback, rx pin unused
// - loop set, source 1: single wire, tx pin joins transmitter and receiver
// - wait-halt bit 0 keeps running in wait state, 1 stops there
// - length bit picks 8-bit or 9-bit characters for both directions
// - resume method bit: idle-line wakeup at 0, address-mark at 1
// - idle count type: count after start bit at 0, after stop at 1
// - idle declared after 10 (8-bit) or 11 (9-bit) bit times of high line
// - parity enable generates and checks parity in the bit before stop
// - parity odd select: even at 0, odd at 1, over data plus parity
// - parity type ignored unless parity is enabled
// - single wire: direction bit decides whether tx line is driven
module uflc_core (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uflc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic tx_out,
	output logic tx_oe,
	input wire logic tx_in,
	input wire logic rx_in,
	input wire logic wait_req,
	output logic halted
);
	logic [12:0] baud_r, baud_nxt;
	logic [7:0] fc_r, fc_nxt;
	logic [3:0] ctrl_r, ctrl_nxt;
	logic [7:0] stat_r, stat_nxt;
	logic [8:0] rx_data_r, rx_data_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	uflc_pkg::uflc_state_t tx_state_r, tx_state_nxt, rx_state_r, rx_state_nxt;
	logic [12:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
	logic [3:0] tx_idx_r, tx_idx_nxt, rx_idx_r, rx_idx_nxt;
	logic [8:0] tx_shift_r, tx_shift_nxt, rx_shift_r, rx_shift_nxt;
	logic tx_line_r, tx_line_nxt, tx_oe_r, tx_oe_nxt;
	logic [12:0] idle_tick_r, idle_tick_nxt;
	logic [3:0] idle_bits_r, idle_bits_nxt;
	logic idle_seen_r, idle_seen_nxt, halted_r, halted_nxt;
	logic [5:0] idx;
	logic mapped, acc, done, halt_req, rx_src, rx_got, rx_ferr, idle_event;
	logic [3:0] len, idle_thr;
	logic [12:0] baud_m1;
	logic f_in_ready, f_in_valid, f_out_valid, f_out_ready;
	logic [8:0] f_out_data;

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign tx_out = tx_line_r;
	assign tx_oe = tx_oe_r;
	assign halted = halted_r;

	// ----------------------------------------------------------------
	// shared decode
	// ----------------------------------------------------------------
	always_comb begin
		idx = paddr[7:2];
		mapped = (paddr[1:0] == 2'b00) && (idx == uflc_pkg::IDX_BAUD
			|| idx == uflc_pkg::IDX_FRAME || idx == uflc_pkg::IDX_CTRL
			|| idx == uflc_pkg::IDX_STAT || idx == uflc_pkg::IDX_DATA);
		acc = psel && penable;
		done = acc && pready_r;
		halt_req = wait_req && fc_r[uflc_pkg::FC_HALT];
		len = fc_r[uflc_pkg::FC_LEN9] ? uflc_pkg::LEN_9 : uflc_pkg::LEN_8;
		idle_thr = fc_r[uflc_pkg::FC_LEN9] ? uflc_pkg::IDLE_BITS_9
			: uflc_pkg::IDLE_BITS_8;
		baud_m1 = baud_r - 13'h0001;
		// the pin is only seen when loop select is clear; source bit
		// matters only under loop select
		if (!fc_r[uflc_pkg::FC_LOOP]) begin
			rx_src = rx_in;
		end else if (!fc_r[uflc_pkg::FC_SRC]) begin
			rx_src = tx_line_r;
		end else begin
			rx_src = ctrl_r[uflc_pkg::CT_DIR] ? tx_line_r : tx_in;
		end
	end

	// ----------------------------------------------------------------
	// transmit fifo: a full fifo holds off the data write's pready
	// ----------------------------------------------------------------
	assign f_in_valid = done && pwrite && mapped && idx == uflc_pkg::IDX_DATA;

	uflc_fifo #(
		.WIDTH(uflc_pkg::CHAR_W),
		.DEPTH(uflc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(core_clk),
		.rst(rst),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data(pwdata[8:0]),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	// ----------------------------------------------------------------
	// register file and apb answer
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] live;
		logic [8:0] word;
		logic accept;
		live = stat_r;
		live[uflc_pkg::ST_TXEMPTY] = !f_out_valid && tx_state_r == uflc_pkg::UFLC_IDLE;
		live[uflc_pkg::ST_TXFULL] = !f_in_ready;
		live[uflc_pkg::ST_HALTED] = halted_r;
		baud_nxt = baud_r;
		fc_nxt = fc_r;
		ctrl_nxt = ctrl_r;
		stat_nxt = stat_r;
		rx_data_nxt = rx_data_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		word = rx_shift_r;
		accept = 1'b0;
		if (acc && !pready_r && (!(pwrite && mapped
			&& idx == uflc_pkg::IDX_DATA) || f_in_ready)) begin
			pready_nxt = 1'b1;
			pslverr_nxt = !mapped;
			prdata_nxt = 32'h0000_0000;
			if (mapped && !pwrite) begin
				case (idx)
				uflc_pkg::IDX_BAUD: prdata_nxt[12:0] = baud_r;
				uflc_pkg::IDX_FRAME: prdata_nxt[7:0] = fc_r;
				uflc_pkg::IDX_CTRL: prdata_nxt[3:0] = ctrl_r;
				uflc_pkg::IDX_STAT: prdata_nxt[7:0] = live;
				uflc_pkg::IDX_DATA: prdata_nxt[8:0] = rx_data_r;
				default: prdata_nxt = 32'h0000_0000;
				endcase
			end
		end
		// wakeup clears first so that a software set in the same cycle wins
		if (rx_got && ctrl_r[uflc_pkg::CT_RWU]) begin
			if (fc_r[uflc_pkg::FC_WAKE]
				&& rx_shift_r[fc_r[uflc_pkg::FC_PEN] ? len - 4'h2 : len - 4'h1]) begin
				ctrl_nxt[uflc_pkg::CT_RWU] = 1'b0;
				accept = 1'b1;
			end
		end else if (rx_got) begin
			accept = 1'b1;
		end
		if (idle_event && !fc_r[uflc_pkg::FC_WAKE]) begin
			ctrl_nxt[uflc_pkg::CT_RWU] = 1'b0;
		end
		if (done && mapped && pwrite) begin
			case (idx)
			uflc_pkg::IDX_BAUD: baud_nxt = pwdata[12:0];
			uflc_pkg::IDX_FRAME: fc_nxt = pwdata[7:0];
			uflc_pkg::IDX_CTRL: ctrl_nxt = pwdata[3:0];
			uflc_pkg::IDX_STAT: stat_nxt = stat_r & ~pwdata[7:0];
			default: stat_nxt = stat_nxt;
			endcase
		end
		if (done && mapped && !pwrite && idx == uflc_pkg::IDX_DATA) begin
			stat_nxt[uflc_pkg::ST_RXFULL] = 1'b0;
		end
		// hardware sets come last: an event beats a clear in the same cycle
		if (accept) begin
			if (fc_r[uflc_pkg::FC_PEN]) begin
				word[len - 4'h1] = 1'b0;
				stat_nxt[uflc_pkg::ST_PERR] = stat_nxt[uflc_pkg::ST_PERR]
					| ((^rx_shift_r) != fc_r[uflc_pkg::FC_PODD]);
			end
			stat_nxt[uflc_pkg::ST_FERR] = stat_nxt[uflc_pkg::ST_FERR] | rx_ferr;
			if (stat_nxt[uflc_pkg::ST_RXFULL]) begin
				stat_nxt[uflc_pkg::ST_OVR] = 1'b1;
			end else begin
				stat_nxt[uflc_pkg::ST_RXFULL] = 1'b1;
				rx_data_nxt = word;
			end
		end
		if (idle_event) begin
			stat_nxt[uflc_pkg::ST_IDLE] = 1'b1;
		end
		stat_nxt[7:5] = 3'h0;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			baud_r <= uflc_pkg::BAUD_RESET;
			fc_r <= uflc_pkg::FC_RESET;
			ctrl_r <= uflc_pkg::CT_RESET;
			stat_r <= 8'h00;
			rx_data_r <= 9'h000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			baud_r <= baud_nxt;
			fc_r <= fc_nxt;
			ctrl_r <= ctrl_nxt;
			stat_r <= stat_nxt;
			rx_data_r <= rx_data_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// transmitter: a disabled or halted unit ends the current character
	// ----------------------------------------------------------------
	always_comb begin
		logic [8:0] word;
		word = f_out_data;
		f_out_ready = 1'b0;
		tx_state_nxt = tx_state_r;
		tx_cnt_nxt = tx_cnt_r - 13'h0001;
		tx_idx_nxt = tx_idx_r;
		tx_shift_nxt = tx_shift_r;
		tx_line_nxt = tx_line_r;
		case (tx_state_r)
		uflc_pkg::UFLC_IDLE: begin
			tx_line_nxt = 1'b1;
			tx_cnt_nxt = baud_m1;
			if (ctrl_r[uflc_pkg::CT_TXEN] && f_out_valid && !halt_req) begin
				f_out_ready = 1'b1;
				if (!fc_r[uflc_pkg::FC_LEN9]) begin
					word[8] = 1'b0;
				end
				if (fc_r[uflc_pkg::FC_PEN]) begin
					word[len - 4'h1] = 1'b0;
					word[len - 4'h1] = (^word) ^ fc_r[uflc_pkg::FC_PODD];
				end
				tx_shift_nxt = word;
				tx_line_nxt = 1'b0;
				tx_state_nxt = uflc_pkg::UFLC_START;
			end
		end
		uflc_pkg::UFLC_START: begin
			if (tx_cnt_r == 13'h0000) begin
				tx_cnt_nxt = baud_m1;
				tx_idx_nxt = 4'h0;
				tx_line_nxt = tx_shift_r[0];
				tx_shift_nxt = tx_shift_r >> 1;
				tx_state_nxt = uflc_pkg::UFLC_DATA;
			end
		end
		uflc_pkg::UFLC_DATA: begin
			if (tx_cnt_r == 13'h0000) begin
				tx_cnt_nxt = baud_m1;
				if (tx_idx_r == len - 4'h1) begin
					tx_line_nxt = 1'b1;
					tx_state_nxt = uflc_pkg::UFLC_STOP;
				end else begin
					tx_idx_nxt = tx_idx_r + 4'h1;
					tx_line_nxt = tx_shift_r[0];
					tx_shift_nxt = tx_shift_r >> 1;
				end
			end
		end
		uflc_pkg::UFLC_STOP: begin
			if (tx_cnt_r == 13'h0000) begin
				tx_state_nxt = uflc_pkg::UFLC_IDLE;
			end
		end
		default: tx_state_nxt = uflc_pkg::UFLC_IDLE;
		endcase
		tx_oe_nxt = ctrl_r[uflc_pkg::CT_TXEN] || tx_state_r != uflc_pkg::UFLC_IDLE;
		if (fc_r[uflc_pkg::FC_LOOP] && fc_r[uflc_pkg::FC_SRC]) begin
			tx_oe_nxt = tx_oe_nxt && ctrl_r[uflc_pkg::CT_DIR];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_state_r <= uflc_pkg::UFLC_IDLE;
			tx_cnt_r <= 13'h0000;
			tx_idx_r <= 4'h0;
			tx_shift_r <= 9'h000;
			tx_line_r <= 1'b1;
			tx_oe_r <= 1'b0;
		end else begin
			tx_state_r <= tx_state_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_idx_r <= tx_idx_nxt;
			tx_shift_r <= tx_shift_nxt;
			tx_line_r <= tx_line_nxt;
			tx_oe_r <= tx_oe_nxt;
		end
	end

	// ----------------------------------------------------------------
	// receiver: mid-bit sampling, no oversampling vote
	// ----------------------------------------------------------------
	always_comb begin
		rx_state_nxt = rx_state_r;
		rx_cnt_nxt = rx_cnt_r - 13'h0001;
		rx_idx_nxt = rx_idx_r;
		rx_shift_nxt = rx_shift_r;
		rx_got = 1'b0;
		rx_ferr = 1'b0;
		case (rx_state_r)
		uflc_pkg::UFLC_IDLE: begin
			rx_cnt_nxt = baud_r >> 1;
			if (ctrl_r[uflc_pkg::CT_RXEN] && !halt_req && !rx_src) begin
				rx_state_nxt = uflc_pkg::UFLC_START;
			end
		end
		uflc_pkg::UFLC_START: begin
			if (rx_cnt_r == 13'h0000) begin
				rx_cnt_nxt = baud_m1;
				rx_idx_nxt = 4'h0;
				rx_shift_nxt = 9'h000;
				rx_state_nxt = rx_src ? uflc_pkg::UFLC_IDLE : uflc_pkg::UFLC_DATA;
			end
		end
		uflc_pkg::UFLC_DATA: begin
			if (rx_cnt_r == 13'h0000) begin
				rx_cnt_nxt = baud_m1;
				rx_shift_nxt[rx_idx_r] = rx_src;
				rx_idx_nxt = rx_idx_r + 4'h1;
				if (rx_idx_r == len - 4'h1) begin
					rx_state_nxt = uflc_pkg::UFLC_STOP;
				end
			end
		end
		uflc_pkg::UFLC_STOP: begin
			if (rx_cnt_r == 13'h0000) begin
				rx_got = 1'b1;
				rx_ferr = !rx_src;
				rx_state_nxt = uflc_pkg::UFLC_IDLE;
			end
		end
		default: rx_state_nxt = uflc_pkg::UFLC_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// idle detector, counted in bit times of high line
	// ----------------------------------------------------------------
	always_comb begin
		idle_event = 1'b0;
		idle_tick_nxt = idle_tick_r;
		idle_bits_nxt = idle_bits_r;
		idle_seen_nxt = idle_seen_r && rx_src;
		halted_nxt = halt_req && tx_state_r == uflc_pkg::UFLC_IDLE
			&& rx_state_r == uflc_pkg::UFLC_IDLE;
		if (!rx_src || !ctrl_r[uflc_pkg::CT_RXEN] || (fc_r[uflc_pkg::FC_ICT]
			&& rx_state_r != uflc_pkg::UFLC_IDLE)) begin
			idle_tick_nxt = 13'h0000;
			idle_bits_nxt = 4'h0;
		end else if (!idle_seen_r) begin
			if (idle_tick_r >= baud_m1) begin
				idle_tick_nxt = 13'h0000;
				idle_bits_nxt = idle_bits_r + 4'h1;
				if (idle_bits_nxt == idle_thr) begin
					idle_event = 1'b1;
					idle_seen_nxt = 1'b1;
				end
			end else begin
				idle_tick_nxt = idle_tick_r + 13'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_state_r <= uflc_pkg::UFLC_IDLE;
			rx_cnt_r <= 13'h0000;
			rx_idx_r <= 4'h0;
			rx_shift_r <= 9'h000;
			idle_tick_r <= 13'h0000;
			idle_bits_r <= 4'h0;
			idle_seen_r <= 1'b0;
			halted_r <= 1'b0;
		end else begin
			rx_state_r <= rx_state_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_idx_r <= rx_idx_nxt;
			rx_shift_r <= rx_shift_nxt;
			idle_tick_r <= idle_tick_nxt;
			idle_bits_r <= idle_bits_nxt;
			idle_seen_r <= idle_seen_nxt;
			halted_r <= halted_nxt;
		end
	end
endmodule

// ### verification/uflc_remote.sv
`timescale 1ns/1ps
module uflc_remote #(
	parameter int BAUD = 4
) (
	input wire logic core_clk,
	input wire logic line_in,
	output logic line_out
);
	int nbits = 8;
	logic [8:0] got[$];
	logic [8:0] sh;
	initial line_out = 1'b1;
	// ----------------------------------------------------------------
	// receive: sample mid bit, lsb first, one stop bit
	// ----------------------------------------------------------------
	always begin
		@(negedge line_in);
		repeat (BAUD / 2) @(posedge core_clk);
		sh = '0;
		for (int i = 0; i < nbits; i++) begin
			repeat (BAUD) @(posedge core_clk);
			sh[i] = line_in;
		end
		repeat (BAUD) @(posedge core_clk);
		got.push_back(sh);
	end
	// ----------------------------------------------------------------
	// transmit one frame, line back to idle high afterwards
	// ----------------------------------------------------------------
	task automatic send(input logic [8:0] w);
		line_out <= 1'b0;
		repeat (BAUD) @(posedge core_clk);
		for (int i = 0; i < nbits; i++) begin
			line_out <= w[i];
			repeat (BAUD) @(posedge core_clk);
		end
		line_out <= 1'b1;
		repeat (BAUD) @(posedge core_clk);
	endtask
endmodule

// ### verification/uflc_core_properties.sv
`timescale 1ns/1ps
module uflc_core_properties (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uflc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic tx_out,
	input wire logic tx_oe,
	input wire logic tx_in,
	input wire logic rx_in,
	input wire logic wait_req,
	input wire logic halted
);
	localparam logic [7:0] A_FC = {uflc_pkg::IDX_FRAME, 2'b00};
	localparam logic [7:0] A_CT = {uflc_pkg::IDX_CTRL, 2'b00};
	localparam logic [7:0] A_DATA = {uflc_pkg::IDX_DATA, 2'b00};
	// ----------------------------------------------------------------
	// shadow of the mode registers, tracked from completed writes
	// ----------------------------------------------------------------
	logic [7:0] fc_r, fc_nxt;
	logic [3:0] ct_r, ct_nxt;
	logic wr_done, dup_on, sw_in, sw_out;
	always_comb begin
		wr_done = psel && penable && pready && pwrite && !pslverr;
		fc_nxt = fc_r;
		ct_nxt = ct_r;
		if (wr_done && paddr == A_FC) begin
			fc_nxt = pwdata[7:0];
		end
		if (wr_done && paddr == A_CT) begin
			ct_nxt = pwdata[3:0];
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fc_r <= uflc_pkg::FC_RESET;
			ct_r <= uflc_pkg::CT_RESET;
		end else begin
			fc_r <= fc_nxt;
			ct_r <= ct_nxt;
		end
	end
	// wait is kept out of these, though halting leaves tx_oe to the enable and busy state
	assign dup_on = ct_r[0] && !fc_r[7] && !wait_req;
	assign sw_in = fc_r[7] && fc_r[5] && !ct_r[2];
	assign sw_out = fc_r[7] && fc_r[5] && ct_r[2] && ct_r[0] && !wait_req;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready)
		else $error("error flag without ready");
	property p_answer;
		psel && penable && !pready && paddr != A_DATA |=> pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("register answer late");
	property p_ready_cause;
		pready |-> $past(psel && penable) ##1 !pready;
	endproperty
	a_ready_cause: assert property (p_ready_cause)
		else $error("ready without access or too long");
	property p_fc_read;
		pready && !pwrite && paddr == A_FC |-> prdata == {24'h0, fc_r};
	endproperty
	a_fc_read: assert property (p_fc_read)
		else $error("frame control read back wrong");
	property p_halt_cause;
		$rose(halted) |-> $past(wait_req) && $past(fc_r[6]);
	endproperty
	a_halt_cause: assert property (p_halt_cause)
		else $error("halt without wait and halt bit");
	property p_run;
		!fc_r[6] && !$past(fc_r[6]) |-> !halted;
	endproperty
	a_run: assert property (p_run)
		else $error("halted with halt bit clear");
	property p_dup_oe;
		dup_on && $past(dup_on) |-> tx_oe;
	endproperty
	a_dup_oe: assert property (p_dup_oe)
		else $error("tx pin not driven in full duplex");
	property p_sw_in;
		sw_in && $past(sw_in) |-> !tx_oe;
	endproperty
	a_sw_in: assert property (p_sw_in)
		else $error("single wire input yet pin driven");
	property p_sw_out;
		sw_out && $past(sw_out) |-> tx_oe;
	endproperty
	a_sw_out: assert property (p_sw_out)
		else $error("single wire output yet pin released");
	c_sw_in: cover property (sw_in ##1 !tx_in);
	c_halt: cover property ($rose(halted));
	c_err: cover property (pslverr);
endmodule
bind uflc_core uflc_core_properties chk (.core_clk, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .tx_out, .tx_oe,
	.tx_in, .rx_in, .wait_req, .halted);

// ### verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		n_checks++; \
		if ((a) !== (b)) begin \
			failures++; \
			$display("ERROR %0t got %h want %h", $time, (a), (b)); \
		end \
	end
module tb_top;
	localparam int BAUD = 4;
	localparam logic [7:0] A_BAUD = {uflc_pkg::IDX_BAUD, 2'b00};
	localparam logic [7:0] A_FC = {uflc_pkg::IDX_FRAME, 2'b00};
	localparam logic [7:0] A_CT = {uflc_pkg::IDX_CTRL, 2'b00};
	localparam logic [7:0] A_ST = {uflc_pkg::IDX_STAT, 2'b00};
	localparam logic [7:0] A_DATA = {uflc_pkg::IDX_DATA, 2'b00};
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic tx_out, tx_oe, tx_in, rx_in, wait_req, halted, remote_out, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int failures = 0;
	int n_checks = 0;
	logic [7:0] tfc[6] = '{8'h02, 8'h03, 8'h01, 8'h02, 8'h12, 8'h10};
	logic [8:0] twd[6] = '{9'h007, 9'h007, 9'h087, 9'h08f, 9'h1a5, 9'h1a5};
	logic [8:0] tex[6] = '{9'h087, 9'h007, 9'h087, 9'h00f, 9'h0a5, 9'h1a5};
	logic [7:0] rfc[4] = '{8'h20, 8'h02, 8'h02, 8'h80};
	logic [8:0] rsd[4] = '{9'h0a5, 9'h087, 9'h007, 9'h011};
	logic [4:0] rmk[4] = '{5'h1f, 5'h1f, 5'h14, 5'h01};
	logic [4:0] rex[4] = '{5'h11, 5'h11, 5'h14, 5'h00};
	logic [8:0] dmk[4] = '{9'h1ff, 9'h1ff, 9'h1ff, 9'h1ff};
	logic [8:0] rdx[4] = '{9'h0a5, 9'h007, 9'h007, 9'h007};
	// the remote drives the shared line, idle high, whenever the core does not
	assign tx_in = tx_oe ? tx_out : remote_out;
	assign rx_in = remote_out;
	uflc_core DUT (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .tx_out, .tx_oe, .tx_in,
		.rx_in, .wait_req, .halted);
	uflc_remote #(.BAUD(BAUD)) remote (.core_clk(core_clk),
		.line_in(tx_oe ? tx_out : 1'b1), .line_out(remote_out));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// ----------------------------------------------------------------
	// bus and helper tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		if (failures == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 200);
		rd = prdata;
		err = pslverr;
		`CHK(n < 200, 1'b1)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cfg(input logic [7:0] fc, input logic [3:0] ct);
		apb(1'b1, A_CT, 32'h0);
		apb(1'b1, A_FC, {24'h0, fc});
		apb(1'b1, A_CT, {28'h0, ct});
		remote.nbits = fc[4] ? 9 : 8;
		remote.got.delete();
	endtask
	task automatic wait_got(input int k);
		int n;
		n = 0;
		while (remote.got.size() < k && n < 4000) begin
			@(posedge core_clk);
			n++;
		end
		`CHK(remote.got.size(), k)
	endtask
	initial begin
		repeat (40000) @(posedge core_clk);
		failures++;
		$display("ERROR %0t watchdog", $time);
		tally_and_finish();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, wait_req} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		apb(1'b0, A_FC, 32'h0);
		`CHK(rd, {24'h0, uflc_pkg::FC_RESET})
		apb(1'b1, A_FC, 32'hff);
		apb(1'b0, A_FC, 32'h0);
		`CHK({err, rd}, {1'b0, 32'h0000_00ff})
		apb(1'b0, 8'h24, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		apb(1'b0, 8'h09, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b1, A_BAUD, BAUD);
		foreach (tfc[i]) begin
			cfg(tfc[i], 4'h3);
			apb(1'b1, A_DATA, {23'h0, twd[i]});
			wait_got(1);
			`CHK(remote.got[0], tex[i])
		end
		foreach (rfc[i]) begin
			cfg(rfc[i], 4'h3);
			apb(1'b1, A_ST, 32'h1f);
			remote.send(rsd[i]);
			repeat (16 * BAUD) @(posedge core_clk);
			apb(1'b0, A_ST, 32'h0);
			`CHK(rd[4:0] & rmk[i], rex[i])
			apb(1'b0, A_DATA, 32'h0);
			`CHK(rd[8:0] & dmk[i], rdx[i])
		end
		apb(1'b1, A_DATA, 32'h3c);
		repeat (16 * BAUD) @(posedge core_clk);
		apb(1'b0, A_DATA, 32'h0);
		`CHK(rd[8:0], 9'h03c)
		cfg(8'ha0, 4'h3);
		remote.send(9'h05c);
		repeat (16 * BAUD) @(posedge core_clk);
		apb(1'b0, A_DATA, 32'h0);
		`CHK(rd[8:0], 9'h05c)
		apb(1'b1, A_CT, 32'h7);
		apb(1'b1, A_DATA, 32'h66);
		wait_got(1);
		`CHK(remote.got[0], 9'h066)
		apb(1'b0, A_DATA, 32'h0);
		`CHK(rd[8:0], 9'h066)
		cfg(8'h40, 4'h3);
		wait_req <= 1'b1;
		apb(1'b1, A_DATA, 32'h55);
		repeat (20 * BAUD) @(posedge core_clk);
		`CHK({halted, remote.got.size() == 0}, 2'b11)
		wait_req <= 1'b0;
		wait_got(1);
		`CHK(remote.got[0], 9'h055)
		cfg(8'h00, 4'h3);
		wait_req <= 1'b1;
		repeat (8) @(posedge core_clk);
		`CHK(halted, 1'b0)
		wait_req <= 1'b0;
		cfg(8'h00, 4'h2);
		for (int i = 1; i <= 8; i++) begin
			apb(1'b1, A_DATA, 32'(i));
		end
		apb(1'b0, A_ST, 32'h0);
		`CHK(rd[6:5], 2'b10)
		apb(1'b1, A_CT, 32'h3);
		apb(1'b1, A_DATA, 32'h9);
		wait_got(9);
		foreach (remote.got[i]) begin
			`CHK(remote.got[i], 9'(i + 1))
		end
		apb(1'b0, A_ST, 32'h0);
		`CHK(rd[6:5], 2'b01)
		cfg(8'h08, 4'hb);
		remote.send(9'h011);
		remote.send(9'h091);
		repeat (16 * BAUD) @(posedge core_clk);
		apb(1'b0, A_DATA, 32'h0);
		`CHK(rd[8:0], 9'h091)
		apb(1'b0, A_CT, 32'h0);
		`CHK(rd[3:0], 4'h3)
		cfg(8'h00, 4'hb);
		remote.send(9'h012);
		repeat (16 * BAUD) @(posedge core_clk);
		apb(1'b0, A_CT, 32'h0);
		`CHK(rd[3:0], 4'h3)
		apb(1'b0, A_DATA, 32'h0);
		`CHK(rd[8:0], 9'h091)
		cfg(8'h04, 4'h3);
		apb(1'b1, A_ST, 32'h1f);
		remote.send(9'h0ff);
		repeat (5 * BAUD) @(posedge core_clk);
		apb(1'b0, A_ST, 32'h0);
		`CHK(rd[4], 1'b0)
		repeat (16 * BAUD) @(posedge core_clk);
		apb(1'b0, A_ST, 32'h0);
		`CHK(rd[4], 1'b1)
		tally_and_finish();
	end
endmodule
